// ---- hdl/pcl_pkg.sv ----
/*
  Constants for the program cache lock control block: instruction
  encodings, field positions, cache geometry and reset values.
  Assumes a 32-bit program address space and one op at a time.
*/
package pcl_pkg;
  // ==========================================================
  // Geometry
  localparam int NUM_SECTORS = 8;
  localparam int SEC_IDX_W = 3;
  localparam int ADDR_W = 32;
  localparam int TAG_W = 25;
  localparam int TAG_LSB = 7;
  localparam logic [TAG_W-1:0] TAG_RESET = 25'h0000000;

  typedef logic [SEC_IDX_W-1:0] pcl_sec_idx_t;

  // ==========================================================
  // Instruction words and match masks
  localparam logic [31:0] FLUSH_WORD = 32'h00000003;
  localparam logic [31:0] UNLOCK_ALL_WORD = 32'h00000002;
  localparam logic [31:0] ABS_LOCK_MASK = 32'hfff03fff;
  localparam logic [31:0] ABS_LOCK_BITS = 32'h03000080;
  localparam logic [31:0] REL_SHORT_MASK = 32'hffc03f80;
  localparam logic [31:0] REL_SHORT_BITS = 32'h03800000;
  localparam logic [31:0] REL_LONG_WORD = 32'h03080000;
  localparam logic [31:0] REL_REG_MASK = 32'hfffe3fff;
  localparam logic [31:0] REL_REG_BITS = 32'h03020000;

  // ==========================================================
  // Field positions
  localparam int EA_MODE_MSB = 19;
  localparam int EA_MODE_LSB = 17;
  localparam int REG_SEL_MSB = 16;
  localparam int REG_SEL_LSB = 14;
  localparam int SHORT_HI_MSB = 21;
  localparam int SHORT_HI_LSB = 14;
  localparam int SHORT_LO_MSB = 6;
  localparam int SHORT_LO_LSB = 0;
  localparam int SHORT_DISP_W = 15;

  // ==========================================================
  // Effective address modes
  localparam logic [2:0] EA_MODE_LAST_RN = 3'h4;
  localparam logic [2:0] EA_MODE_ABS = 3'h6;
  localparam logic [2:0] EA_REG_ABS = 3'h0;
endpackage

// ---- hdl/pcl_sector.sv ----
/*
  One cache sector's tag, tag-valid and lock state with tag compare.
  Assumes the controller asserts alloc only together with lock, and flush or unlock-all apart from both.
*/
`timescale 1ns/100ps
`default_nettype none
module pcl_sector (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Commands
  input wire logic i_flush,
  input wire logic i_unlock_all,
  input wire logic i_alloc,
  input wire logic i_lock,
  input wire logic [pcl_pkg::TAG_W-1:0] i_tag,
  // State
  output logic o_hit,
  output logic o_valid,
  output logic o_locked
);
  logic [pcl_pkg::TAG_W-1:0] tag_ff;
  logic valid_ff;
  logic locked_ff;

  // ==========================================================
  // Tag store
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tag_ff <= pcl_pkg::TAG_RESET;
      valid_ff <= 1'b0;
    end else if (i_flush) begin
      tag_ff <= pcl_pkg::TAG_RESET;
      valid_ff <= 1'b0;
    end else if (i_alloc) begin
      tag_ff <= i_tag;
      valid_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Lock state
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      locked_ff <= 1'b0;
    end else if (i_flush || i_unlock_all) begin
      locked_ff <= 1'b0;
    end else if (i_lock) begin
      locked_ff <= 1'b1;
    end
  end

  assign o_hit = valid_ff && (tag_ff == i_tag);
  assign o_valid = valid_ff;
  assign o_locked = locked_ff;
endmodule
`default_nettype wire

// ---- hdl/pcl_lock_ctrl.sv ----
/*
  Program cache lock control: executes cache flush, global unlock,
  absolute sector lock and PC-relative sector lock, keeping sector
  tags, lock bits and an LRU stack.
  Assumes the decoder presents one op per i_op_valid cycle together
  with its extension word, the current PC and the address registers.
*/
// Contract
// - Flush invalidates, unlocks, resets LRU and tags
// - Flush works in cache and RAM modes
// - Flush word is 0x00000003 exactly
// - Global unlock clears locks only
// - Global unlock works in both modes
// - Global unlock word is 0x00000002 exactly
// - Absolute lock on tag hit locks sector
// - Miss loads tag into deepest unlocked stack sector and locks it on the same edge
// - Every lock updates LRU stack; a miss with all sectors locked leaves it unchanged
// - Memory-alterable modes only, no short absolute
// - Address from R0-R7 or absolute word
// - Absolute lock traps in program RAM mode
// - Relative lock traps in program RAM mode
// - Absolute lock word fields decoded exactly
// - Relative lock uses PC plus displacement
// - Displacement is signed 32-bit value
// - Short displacement sign-extended from 15 bits
// - Short displacement joined from split fields
// - Long form takes extension word displacement
// - Register form takes selected address register
`timescale 1ns/100ps
`default_nettype none
module pcl_lock_ctrl (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Decoded operation
  input wire logic i_op_valid,
  input wire logic [31:0] i_op_word,
  input wire logic [31:0] i_ext_word,
  input wire logic [31:0] i_pc,
  input wire logic [7:0][31:0] i_areg,
  // Mode
  input wire logic i_program_ram_mode,
  // Results
  output logic o_op_done,
  output logic o_illegal_trap,
  output logic o_lock_hit,
  output logic [2:0] o_lock_sector,
  output logic [31:0] o_lock_addr,
  // Cache state
  output logic [7:0] o_valid_vec,
  output logic [7:0] o_lock_vec,
  output logic [2:0] o_lru_sector
);
  localparam int NS = pcl_pkg::NUM_SECTORS;

  // ==========================================================
  // Decode
  wire logic [31:0] w = i_op_word;
  wire logic is_flush = (w == pcl_pkg::FLUSH_WORD);
  wire logic is_unlock = (w == pcl_pkg::UNLOCK_ALL_WORD);
  wire logic is_abs = ((w & pcl_pkg::ABS_LOCK_MASK) == pcl_pkg::ABS_LOCK_BITS);
  wire logic is_rel_s = ((w & pcl_pkg::REL_SHORT_MASK) == pcl_pkg::REL_SHORT_BITS);
  wire logic is_rel_l = (w == pcl_pkg::REL_LONG_WORD);
  wire logic is_rel_r = ((w & pcl_pkg::REL_REG_MASK) == pcl_pkg::REL_REG_BITS);
  wire logic is_rel = is_rel_s || is_rel_l || is_rel_r;
  wire logic [2:0] ea_mode_field = w[pcl_pkg::EA_MODE_MSB:pcl_pkg::EA_MODE_LSB];
  wire logic [2:0] addr_reg_select = w[pcl_pkg::REG_SEL_MSB:pcl_pkg::REG_SEL_LSB];

  // Pre-modified Rn is the address; modes needing an offset register are refused
  wire logic ea_is_abs = (ea_mode_field == pcl_pkg::EA_MODE_ABS) && (addr_reg_select == pcl_pkg::EA_REG_ABS);
  wire logic ea_mode_ok = (ea_mode_field <= pcl_pkg::EA_MODE_LAST_RN) || ea_is_abs;
  wire logic [31:0] sel_areg = i_areg[addr_reg_select];
  wire logic [31:0] abs_ea = ea_is_abs ? i_ext_word : sel_areg;

  // ==========================================================
  // Relative address
  wire logic [pcl_pkg::SHORT_DISP_W-1:0] short_disp = {w[pcl_pkg::SHORT_HI_MSB:pcl_pkg::SHORT_HI_LSB],
                                                       w[pcl_pkg::SHORT_LO_MSB:pcl_pkg::SHORT_LO_LSB]};
  wire logic [31:0] short_sext = {{(32 - pcl_pkg::SHORT_DISP_W){short_disp[pcl_pkg::SHORT_DISP_W-1]}},
                                  short_disp};
  wire logic [31:0] rel_disp = is_rel_s ? short_sext : (is_rel_l ? i_ext_word : sel_areg);
  wire logic [31:0] rel_addr = i_pc + rel_disp;

  // ==========================================================
  // Execution qualifiers
  wire logic lock_op = i_op_valid && ((is_abs && ea_mode_ok) || is_rel);
  wire logic bad_ea = i_op_valid && is_abs && !ea_mode_ok;
  wire logic trap_now = (lock_op && i_program_ram_mode) || bad_ea;
  wire logic do_lock = lock_op && !i_program_ram_mode;
  wire logic do_flush = i_op_valid && is_flush;
  wire logic do_unlock = i_op_valid && is_unlock;
  wire logic [31:0] lock_addr = is_abs ? abs_ea : rel_addr;
  wire logic [pcl_pkg::TAG_W-1:0] lock_tag = lock_addr[pcl_pkg::ADDR_W-1:pcl_pkg::TAG_LSB];

  // ==========================================================
  // Sectors
  wire logic [NS-1:0] hit_vec;
  wire logic [NS-1:0] valid_vec;
  wire logic [NS-1:0] lock_vec;
  pcl_pkg::pcl_sec_idx_t lru_ff [NS];
  pcl_pkg::pcl_sec_idx_t nxt_lru [NS];
  pcl_pkg::pcl_sec_idx_t hit_idx;
  pcl_pkg::pcl_sec_idx_t victim_idx;
  pcl_pkg::pcl_sec_idx_t ref_pos;
  logic victim_found;

  wire logic any_hit = |hit_vec;
  wire logic do_alloc = do_lock && !any_hit && victim_found;
  wire logic do_ref = do_lock && (any_hit || victim_found);
  wire pcl_pkg::pcl_sec_idx_t ref_idx = any_hit ? hit_idx : victim_idx;

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sec
      wire logic sel = (ref_idx == pcl_pkg::pcl_sec_idx_t'(g));
      pcl_sector u_sector (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_flush(do_flush),
        .i_unlock_all(do_unlock),
        .i_alloc(do_alloc && sel),
        .i_lock(do_ref && sel),
        .i_tag(lock_tag),
        .o_hit(hit_vec[g]),
        .o_valid(valid_vec[g]),
        .o_locked(lock_vec[g])
      );
    end
  endgenerate

  // Tags are unique since allocation only happens on a miss, so OR-encoding is safe
  always_comb begin
    hit_idx = '0;
    for (int i = 0; i < NS; i++) begin
      if (hit_vec[i]) begin
        hit_idx = hit_idx | pcl_pkg::pcl_sec_idx_t'(i);
      end
    end
  end

  // Deepest unlocked stack entry is the victim
  always_comb begin
    victim_idx = lru_ff[NS-1];
    victim_found = 1'b0;
    for (int i = 0; i < NS; i++) begin
      if (!lock_vec[lru_ff[i]]) begin
        victim_idx = lru_ff[i];
        victim_found = 1'b1;
      end
    end
  end

  always_comb begin
    ref_pos = pcl_pkg::pcl_sec_idx_t'(NS - 1);
    for (int i = 0; i < NS; i++) begin
      if (lru_ff[i] == ref_idx) begin
        ref_pos = pcl_pkg::pcl_sec_idx_t'(i);
      end
    end
  end

  // ==========================================================
  // LRU stack, entry 0 is most recent
  generate
    for (g = 0; g < NS; g++) begin : g_lru
      if (g == 0) begin : g_top
        assign nxt_lru[g] = do_ref ? ref_idx : lru_ff[g];
      end else begin : g_rest
        assign nxt_lru[g] = (do_ref && (pcl_pkg::pcl_sec_idx_t'(g) <= ref_pos)) ? lru_ff[g-1] : lru_ff[g];
      end
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lru_ff[g] <= pcl_pkg::pcl_sec_idx_t'(g);
        end else if (do_flush) begin
          lru_ff[g] <= pcl_pkg::pcl_sec_idx_t'(g);
        end else begin
          lru_ff[g] <= nxt_lru[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Result registers; no condition or status bits are driven here
  logic done_ff;
  logic trap_ff;
  logic hit_ff;
  pcl_pkg::pcl_sec_idx_t sector_ff;
  logic [31:0] addr_ff;
  wire logic nxt_done = do_flush || do_unlock || do_lock;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_ff <= 1'b0;
      trap_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      trap_ff <= trap_now;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hit_ff <= 1'b0;
      sector_ff <= '0;
      addr_ff <= '0;
    end else if (do_lock) begin
      hit_ff <= any_hit;
      sector_ff <= ref_idx;
      addr_ff <= lock_addr;
    end
  end

  assign o_op_done = done_ff;
  assign o_illegal_trap = trap_ff;
  assign o_lock_hit = hit_ff;
  assign o_lock_sector = sector_ff;
  assign o_lock_addr = addr_ff;
  assign o_valid_vec = valid_vec;
  assign o_lock_vec = lock_vec;
  assign o_lru_sector = lru_ff[NS-1];

  // ==========================================================
  // Assertion helpers
  // The stack must stay a permutation and a victim must be the deepest
  // free entry; a slip in either only shows up much later as a bad hit.
  logic [NS-1:0] stk_seen;
  logic deeper_free;

  always_comb begin
    stk_seen = '0;
    deeper_free = 1'b0;
    for (int i = 0; i < NS; i++) begin
      stk_seen[lru_ff[i]] = 1'b1;
      if ((i > int'(ref_pos)) && !lock_vec[lru_ff[i]]) begin
        deeper_free = 1'b1;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  flush_clears_a: assert property (do_flush |=> (o_lock_vec == 8'h00) && (o_valid_vec == 8'h00)
    && (o_lru_sector == 3'h7) && (lru_ff[0] == 3'h0)) else $error("flush left state behind");
  flush_any_mode_a: assert property (do_flush && i_program_ram_mode |=> o_op_done && !o_illegal_trap)
    else $error("flush refused in ram mode");
  flush_word_a: assert property (i_op_valid && (i_op_word == 32'h00000003) |=> o_op_done
    && (o_valid_vec == 8'h00)) else $error("flush word not decoded");
  unlock_keeps_a: assert property (do_unlock |=> (o_lock_vec == 8'h00) && $stable(o_valid_vec)
    && (lru_ff[0] == $past(lru_ff[0]))) else $error("unlock changed more than locks");
  unlock_any_mode_a: assert property (i_op_valid && (i_op_word == 32'h00000002) |=> o_op_done
    && !o_illegal_trap) else $error("unlock word not accepted");
  unlock_word_a: assert property (i_op_valid && (i_op_word == 32'h00000012) && !is_rel && !is_abs
    |=> !o_op_done) else $error("near-unlock word accepted");
  hit_lock_a: assert property (do_lock && any_hit |=> o_lock_hit && o_lock_vec[o_lock_sector])
    else $error("hit sector not locked");
  alloc_lru_a: assert property (do_alloc |=> !o_lock_hit && (o_lock_sector == $past(victim_idx))
    && o_valid_vec[o_lock_sector] && o_lock_vec[o_lock_sector]) else $error("miss did not allocate victim");
  lru_update_a: assert property (do_ref |=> (lru_ff[0] == o_lock_sector))
    else $error("lru top not referenced sector");
  bad_mode_a: assert property (bad_ea |=> o_illegal_trap && !o_op_done)
    else $error("bad ea mode not trapped");
  abs_ea_a: assert property (do_lock && is_abs && !ea_is_abs |=> o_lock_addr == $past(sel_areg))
    else $error("register ea wrong");
  ram_trap_a: assert property (lock_op && i_program_ram_mode |=> o_illegal_trap && !o_op_done
    && $stable(o_lock_vec)) else $error("lock in ram mode not trapped");
  rel_trap_a: assert property (i_op_valid && is_rel && i_program_ram_mode |=> o_illegal_trap
    && (o_valid_vec == $past(o_valid_vec)) && $stable(o_lock_vec))
    else $error("relative lock in ram mode changed cache");
  abs_decode_a: assert property (i_op_valid && ((i_op_word & 32'hfff03fff) == 32'h03000080)
    && !i_program_ram_mode |=> o_op_done || o_illegal_trap) else $error("absolute lock word not decoded");
  rel_sum_a: assert property (do_lock && is_rel |=> o_lock_addr == $past(rel_addr))
    else $error("relative address wrong");
  rel_wrap_a: assert property (do_lock && is_rel_l |=> o_lock_addr == $past(i_pc) + $past(i_ext_word))
    else $error("long displacement sum wrong");
  short_sext_a: assert property (i_op_valid && is_rel_s |-> (rel_disp[31:14] == {18{i_op_word[21]}}))
    else $error("short displacement not sign extended");
  short_join_a: assert property (i_op_valid && is_rel_s |-> (rel_disp[13:7] == i_op_word[20:14])
    && (rel_disp[6:0] == i_op_word[6:0])) else $error("short displacement misassembled");
  long_disp_a: assert property (i_op_valid && is_rel_l |-> rel_disp == i_ext_word)
    else $error("long displacement not from extension word");
  reg_disp_a: assert property (i_op_valid && is_rel_r |-> rel_disp == i_areg[i_op_word[16:14]])
    else $error("register displacement wrong");
  victim_free_a: assert property (do_alloc |-> !lock_vec[victim_idx] ##1 !o_lock_hit)
    else $error("locked sector chosen as victim");

  // ==========================================================
  // Stack, victim and result checks
  victim_deep_a: assert property (do_alloc |-> !deeper_free)
    else $error("victim not deepest free entry");
  full_keep_a: assert property (do_lock && !any_hit && !victim_found |=> o_op_done
    && $stable(o_lock_vec) && $stable(o_valid_vec)) else $error("full miss changed cache");
  lru_perm_a: assert property (stk_seen == 8'hff)
    else $error("lru entry lost");
  lru_hold_a: assert property (!do_ref && !do_flush |=> $stable(o_lru_sector))
    else $error("lru moved without reference");
  sector_idx_a: assert property (do_ref |=> o_lock_sector == $past(ref_idx))
    else $error("wrong sector reported");
  flush_stack_a: assert property (do_flush |=> (lru_ff[1] == 3'h1) && (lru_ff[2] == 3'h2)
    && (lru_ff[3] == 3'h3) && (lru_ff[4] == 3'h4) && (lru_ff[5] == 3'h5) && (lru_ff[6] == 3'h6))
    else $error("flush left stack out of order");
  flush_keep_a: assert property (do_flush |=> $stable(o_lock_addr) && $stable(o_lock_hit))
    else $error("flush moved lock result");
  hit_onehot_a: assert property ($onehot0(hit_vec))
    else $error("address hit two sectors");
  hit_keeps_a: assert property (do_lock && any_hit |=> $stable(o_valid_vec))
    else $error("hit changed tag valid bits");
  lock_sticky_a: assert property (!do_flush && !do_unlock |=> ((o_lock_vec & $past(o_lock_vec))
    == $past(o_lock_vec))) else $error("lock lost without unlock");
  unlock_result_a: assert property (do_unlock |=> $stable(o_lock_addr) && $stable(o_lru_sector))
    else $error("unlock moved results");
  valid_sticky_a: assert property (!do_flush |=> ((o_valid_vec & $past(o_valid_vec))
    == $past(o_valid_vec))) else $error("tag valid lost without flush");
  hold_result_a: assert property (!do_lock |=> $stable(o_lock_addr) && $stable(o_lock_sector)
    && $stable(o_lock_hit)) else $error("lock result moved without lock");
  trap_keeps_a: assert property (trap_now |=> $stable(o_valid_vec) && $stable(o_lock_vec)
    && $stable(o_lru_sector)) else $error("trap changed cache state");
  done_trap_a: assert property (!(o_op_done && o_illegal_trap))
    else $error("done and trap together");
  done_src_a: assert property (o_op_done |-> $past(nxt_done))
    else $error("done without executed op");
  trap_src_a: assert property (o_illegal_trap |-> $past(trap_now))
    else $error("trap without trapped op");
  ignore_word_a: assert property (i_op_valid && !(is_flush || is_unlock || is_abs || is_rel)
    |=> !o_op_done && !o_illegal_trap) else $error("unknown word answered");
  abs_ext_a: assert property (do_lock && is_abs && ea_is_abs |=> o_lock_addr == $past(i_ext_word))
    else $error("absolute ea not from extension word");
  rel_reg_a: assert property (do_lock && is_rel_r |=> o_lock_addr == $past(i_pc) + $past(sel_areg))
    else $error("register relative address wrong");
  short_sum_a: assert property (do_lock && is_rel_s |=> o_lock_addr == $past(i_pc) + $past(short_sext))
    else $error("short relative address wrong");

  flush_c: cover property (do_flush ##1 o_op_done);
  hit_c: cover property (do_alloc ##[1:4] (do_lock && any_hit));
  full_c: cover property (do_lock && !victim_found);
  trap_c: cover property (lock_op && i_program_ram_mode ##1 o_illegal_trap);
  unlock_c: cover property (do_unlock ##1 o_op_done);
endmodule
`default_nettype wire

// ---- testbench/pcl_decoder_model.sv ----
/*
  Decoder and sequencer model: presents one op per call to the cache
  lock control. Assumes calls start just after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module pcl_decoder_model (
  // Clock
  input wire logic i_clk_sys,
  // Op to the cache control
  output logic o_op_valid,
  output logic [31:0] o_op_word,
  output logic [31:0] o_ext_word,
  output logic [31:0] o_pc,
  output logic [7:0][31:0] o_areg,
  output logic o_program_ram_mode
);
  initial begin
    o_op_valid = 1'b0;
    o_op_word = 32'h0;
    o_ext_word = 32'h0;
    o_pc = 32'h0;
    o_areg = 256'h0;
    o_program_ram_mode = 1'b0;
  end
  // ==========================================================
  // Op held from just after one edge up to the taking edge
  task automatic issue(input logic [31:0] w, x, pc, input logic [7:0][31:0] ar, input logic ram);
    #1;
    o_op_valid = 1'b1;
    o_op_word = w;
    o_ext_word = x;
    o_pc = pc;
    o_areg = ar;
    o_program_ram_mode = ram;
    @(posedge i_clk_sys);
  endtask
  // Released lines flip, so a stale word is never read as held
  task automatic idle();
    #1;
    o_op_valid = 1'b0;
    o_op_word = ~o_op_word;
    o_ext_word = ~o_ext_word;
    @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- testbench/program_cache_lock_control_tb_top.sv ----
/*
  Self-checking bench for pcl_lock_ctrl with a reference cache model.
  Assumes the decoder model drives every op input of the design.
*/
`timescale 1ns/100ps
`default_nettype none
module program_cache_lock_control_tb_top;
  typedef struct packed {
    logic [31:0] cyc;
    logic done;
    logic trap;
    logic hit;
    logic [2:0] sec;
    logic [31:0] addr;
    logic [7:0] vv;
    logic [7:0] lv;
    logic [2:0] lru;
  } pcl_note_t;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  wire logic op_valid, ram_mode, o_op_done, o_illegal_trap, o_lock_hit;
  wire logic [31:0] op_word, ext_word, pc, o_lock_addr;
  wire logic [7:0][31:0] areg_w;
  wire logic [2:0] o_lock_sector, o_lru_sector;
  wire logic [7:0] o_valid_vec, o_lock_vec;
  logic [24:0] m_tag [8];
  logic [2:0] m_stk [8];
  logic [7:0] m_val, m_lk;
  logic m_hit;
  logic [2:0] m_sec;
  logic [31:0] m_addr;
  logic [7:0][31:0] areg;
  pcl_note_t q [$];
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 35950;

  pcl_decoder_model pcl_decoder_model_inst (.i_clk_sys(i_clk_sys), .o_op_valid(op_valid), .o_op_word(op_word),
    .o_ext_word(ext_word), .o_pc(pc), .o_areg(areg_w), .o_program_ram_mode(ram_mode));
  pcl_lock_ctrl pcl_lock_ctrl_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_op_valid(op_valid),
    .i_op_word(op_word), .i_ext_word(ext_word), .i_pc(pc), .i_areg(areg_w), .i_program_ram_mode(ram_mode),
    .o_op_done(o_op_done), .o_illegal_trap(o_illegal_trap), .o_lock_hit(o_lock_hit),
    .o_lock_sector(o_lock_sector), .o_lock_addr(o_lock_addr), .o_valid_vec(o_valid_vec),
    .o_lock_vec(o_lock_vec), .o_lru_sector(o_lru_sector));

  always #10 i_clk_sys = ~i_clk_sys;
  // Counted on the falling edge so stamps never race the drivers
  always @(negedge i_clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      $display("Timeout at %0t", $time);
      finish_test();
    end
  end

  // ==========================================================
  // Reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input pcl_note_t e, g);
    check_count = check_count + 1;
    if (e !== g) begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic pcl_note_t obs();
    return '{cyc[31:0], o_op_done, o_illegal_trap, o_lock_hit, o_lock_sector, o_lock_addr, o_valid_vec,
      o_lock_vec, o_lru_sector};
  endfunction

  // ==========================================================
  // Reference cache
  task automatic m_front(input logic [2:0] s);
    int p;
    p = 0;
    for (int i = 0; i < 8; i++) if (m_stk[i] == s) p = i;
    for (int i = 7; i > 0; i--) if (i <= p) m_stk[i] = m_stk[i-1];
    m_stk[0] = s;
  endtask
  task automatic m_flush();
    for (int i = 0; i < 8; i++) m_tag[i] = 25'h0;
    for (int i = 0; i < 8; i++) m_stk[i] = i[2:0];
    m_val = 8'h0;
    m_lk = 8'h0;
  endtask
  task automatic m_lock(input logic [31:0] ea);
    int v;
    v = -1;
    m_addr = ea;
    m_hit = 1'b0;
    for (int i = 0; i < 8; i++) if (m_val[i] && m_tag[i] == ea[31:7]) v = i;
    m_hit = (v >= 0);
    // Deepest unlocked stack entry is the victim; locked ones are skipped
    if (!m_hit) for (int i = 7; i >= 0; i--) if (v < 0 && !m_lk[m_stk[i]]) v = m_stk[i];
    m_sec = (v < 0) ? m_stk[7] : v[2:0];
    if (v < 0) return;
    m_tag[v] = ea[31:7];
    m_val[v] = 1'b1;
    m_lk[v] = 1'b1;
    m_front(v[2:0]);
  endtask

  // Kinds: 0 flush, 1 unlock, 2 abs, 3 short, 4 long, 5 reg, 6 unknown word
  task automatic run_op(input int kind, input logic [2:0] md, rg, input logic [31:0] v, p, input logic ram);
    logic [31:0] w, ea, ec;
    logic trap;
    ec = cyc + 1;
    ea = 32'h0;
    trap = ram && kind >= 2;
    case (kind)
      0: w = 32'h00000003;
      1: w = 32'h00000002;
      2: begin
        w = 32'h03000080 | {md, rg, 14'h0};
        ea = (md <= 3'h4) ? areg[rg] : v;
        trap = trap || md == 3'h5 || md == 3'h7 || (md == 3'h6 && rg != 3'h0);
      end
      3: begin
        w = 32'h03800000 | {v[14:7], 14'h0} | v[6:0];
        ea = p + {{17{v[14]}}, v[14:0]};
      end
      4: begin
        w = 32'h03080000;
        ea = p + v;
      end
      5: begin
        w = 32'h03020000 | {rg, 14'h0};
        ea = p + areg[rg];
      end
      default: w = (v[0]) ? {30'h00c02000, v[1], 1'b1} : {27'h0, 1'b1, 3'h1, v[1]};
    endcase
    pcl_decoder_model_inst.issue(w, v, p, areg, ram);
    if (kind == 6) return;
    if (trap) ;
    else if (kind == 0) m_flush();
    else if (kind == 1) m_lk = 8'h0;
    else m_lock(ea);
    q.push_back(pcl_note_t'{ec, !trap, trap, m_hit, m_sec, m_addr, m_val, m_lk, m_stk[7]});
  endtask

  // ==========================================================
  // Result watcher
  always @(posedge i_clk_sys) begin
    #2;
    if (o_op_done === 1'b1 || o_illegal_trap === 1'b1) begin
      if (q.size() == 0) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b0, obs());
      end else begin
        check(q.pop_front(), obs());
      end
    end
  end

  initial begin
    int k, r;
    m_flush();
    m_hit = 1'b0;
    m_sec = 3'h0;
    m_addr = 32'h0;
    for (int i = 0; i < 8; i++) areg[i] = {i[24:0], 7'h11};
    repeat (20) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    @(posedge i_clk_sys);
    #2 check(pcl_note_t'{cyc[31:0], 1'b0, 1'b0, 1'b0, 3'h0, 32'h0, 8'h0, 8'h0, 3'h7}, obs());
    $display("test reset done");
    @(posedge i_clk_sys);
    for (int i = 0; i < 8; i++) run_op(2, 3'h4, i[2:0], 32'h0, 32'h0, 1'b0);
    run_op(2, 3'h6, 3'h0, 32'h00001000, 32'h0, 1'b0);
    run_op(3, 3'h0, 3'h0, 32'h00007f80, 32'h00000200, 1'b0);
    run_op(4, 3'h0, 3'h0, 32'hffffff00, 32'h00000300, 1'b0);
    run_op(5, 3'h0, 3'h5, 32'h0, 32'h0, 1'b0);
    for (int i = 2; i < 6; i++) run_op(i, 3'h4, 3'h1, 32'h0, 32'h0, 1'b1);
    for (int i = 5; i < 8; i++) run_op(2, i[2:0], 3'h1, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) run_op(6, 3'h0, 3'h0, i, 32'h0, 1'b0);
    run_op(1, 3'h0, 3'h0, 32'h0, 32'h0, 1'b1);
    run_op(2, 3'h6, 3'h0, 32'h00001000, 32'h0, 1'b0);
    run_op(0, 3'h0, 3'h0, 32'h0, 32'h0, 1'b1);
    pcl_decoder_model_inst.idle();
    $display("test directed done");
    for (int n = 0; n < 400; n++) begin
      for (int i = 0; i < 8; i++) areg[i] = $random(seed) & 32'h000007ff;
      k = $unsigned($random(seed)) % 7;
      r = $random(seed);
      if (k == 0 && r[5:3] != 3'h0) k = 2;
      run_op(k, r[2:0], r[8:6], $random(seed) & 32'h00007fff, $random(seed) & 32'h000007ff, r[11:9] == 3'h0);
      if (r[14:12] == 3'h0) pcl_decoder_model_inst.idle();
    end
    repeat (3) pcl_decoder_model_inst.idle();
    $display("test random done");
    if (q.size() != 0) begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 32'h0, q.size());
    end
    finish_test();
  end
endmodule
`default_nettype wire
